/* File: rtl/fps_ctrl.sv */
/*
  fps_ctrl: host-side controller that issues program, erase, suspend,
  resume and status-read frames to a serial nor flash.
  assumes: software drives it over axi4-lite and issues write enable (06h)
  itself; flash io pins are resolved by the surroundings from io_o/io_oe.
*/
// Local design decisions: the register offsets and the AXI4-Lite register port.
// Notes on behaviour
// - quad page program: 32h, 24-bit address, 1..256 data bytes, all on four lines
// - sector erase is 20h plus 24-bit address, clears a 4K-byte sector
// - 32K-byte block erase is 52h plus 24-bit address
// - 64K-byte block erase is d8h plus 24-bit address
// - whole-array erase is c7h or 60h with no address
// - chip select rises only at a byte boundary after the last bit
// - while erase is suspended, no status write and no erase opcodes
// - while program is suspended, no status write and no program opcodes
// - after resume, wait the suspend latency before the next suspend
// - chip select stays low through the whole quad program frame
module fps_ctrl
  import fps_pkg::*;
#(
  parameter int unsigned SUSP_LAT_NS = 20000
) (
  // clock and reset
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // axi4-lite write address and data
  input  wire logic [AXI_AW-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  // axi4-lite write response
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  // axi4-lite read
  input  wire logic [AXI_AW-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // flash pins
  output fps_pins_t              flash_o,
  input  wire logic [3:0]        flash_io_i
);

  localparam int unsigned SUSP_CYC_I = (SUSP_LAT_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [15:0] SUSP_CYC   = 16'(SUSP_CYC_I);

  fps_state_t  state;
  fps_kind_t   kind;
  logic [7:0]  page_buf [0:255];
  logic [7:0]  op_r;
  logic [23:0] addr_r;
  logic [8:0]  len_r;
  logic [9:0]  n_tx;
  logic        quad_r;
  logic        want_rx;
  logic        erase_susp;
  logic        prog_susp;
  logic        refused;
  logic [15:0] guard;
  logic [7:0]  stat_byte;
  logic [7:0]  sh;
  logic [2:0]  units_left;
  logic [3:0]  rx_left;
  logic [7:0]  rx_sh;
  logic [8:0]  byte_idx;
  logic [3:0]  div_cnt;
  logic [3:0]  io_s1;
  logic [3:0]  io_s2;
  logic        wr_take;
  logic        rd_take;
  logic        cmd_sel;
  logic        cmd_bad;
  logic        cmd_go;
  logic [7:0]  wr_op;
  logic [9:0]  len_eff;
  logic [9:0]  next_n_tx;
  logic [31:0] rd_data;
  logic        rd_err;
  logic        wr_err;
  fps_lane_t   lane_nx;
  fps_lane_t   lane_op;

  function automatic fps_lane_t lane_load(input logic [7:0] b, input logic q);
    fps_lane_t l;
    l.io   = q ? b[7:4] : {3'b000, b[7]};
    l.sh   = q ? {b[3:0], 4'h0} : {b[6:0], 1'b0};
    l.left = q ? 3'd1 : 3'd7;
    return l;
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                        input logic [3:0] s);
    logic [31:0] r;
    r = o;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) begin
        r[i*8 +: 8] = n[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // pin inputs through two flops, only io_s2 is read
  always_ff @(posedge aclk) begin
    io_s1 <= flash_io_i;
    io_s2 <= io_s1;
  end

  // write and read channel handshakes
  assign wr_take = s_axi_awready && s_axi_awvalid && s_axi_wvalid;
  assign rd_take = s_axi_arready && s_axi_arvalid;
  assign wr_op   = s_axi_wdata[7:0];
  assign cmd_sel = wr_take && s_axi_awaddr == REG_CMD && s_axi_wstrb[0];
  assign wr_err  = !(s_axi_awaddr == REG_CMD || s_axi_awaddr == REG_ADDR ||
                     s_axi_awaddr == REG_LEN || s_axi_awaddr == REG_STAT ||
                     (s_axi_awaddr >= BUF_BASE && s_axi_awaddr <= BUF_END));

  assign len_eff = (len_r == 9'd0) ? 10'd1 :
                   (len_r > PAGE_BYTES) ? {1'b0, PAGE_BYTES} : {1'b0, len_r};

  always_comb begin
    next_n_tx = 10'd1;
    if (is_prog(wr_op) || wr_op == OP_SE || wr_op == OP_BE32 || wr_op == OP_BE64) begin
      next_n_tx = next_n_tx + ADDR_BYTES;
    end
    if (wr_op == OP_PP || wr_op == OP_QPP) begin
      next_n_tx = next_n_tx + len_eff;
    end
  end

  // erase lock, program lock, no suspend of chip erase
  always_comb begin
    cmd_bad = state != ST_IDLE;
    if (erase_susp && (is_erase(wr_op) || wr_op == OP_WRSR)) begin
      cmd_bad = 1'b1;
    end
    if (prog_susp && (is_prog(wr_op) || wr_op == OP_WRSR)) begin
      cmd_bad = 1'b1;
    end
    if (wr_op == OP_SUSP && (guard != 16'h0 || kind == KIND_CHIP)) begin
      cmd_bad = 1'b1;
    end
  end
  assign cmd_go = cmd_sel && !cmd_bad;

  // axi handshake and response flops
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rresp   <= RESP_OKAY;
      s_axi_rdata   <= 32'h0;
    end else begin
      s_axi_awready <= !s_axi_awready && !s_axi_bvalid && s_axi_awvalid && s_axi_wvalid;
      s_axi_wready  <= !s_axi_awready && !s_axi_bvalid && s_axi_awvalid && s_axi_wvalid;
      if (wr_take) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_err ? RESP_SLVERR : RESP_OKAY;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (rd_take) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_data;
        s_axi_rresp  <= rd_err ? RESP_SLVERR : RESP_OKAY;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // read decode
  always_comb begin
    rd_data = 32'h0;
    rd_err  = 1'b0;
    if (s_axi_araddr >= BUF_BASE && s_axi_araddr <= BUF_END) begin
      for (int i = 0; i < 4; i++) begin
        rd_data[i*8 +: 8] = page_buf[{s_axi_araddr[7:2], 2'(i)}];
      end
    end else begin
      case (s_axi_araddr)
        REG_CMD:  rd_data = {24'h0, op_r};
        REG_ADDR: rd_data = {8'h0, addr_r};
        REG_LEN:  rd_data = {23'h0, len_r};
        REG_STAT: rd_data = {16'h0, stat_byte, 3'b000, guard != 16'h0, prog_susp,
                             erase_susp, refused, state != ST_IDLE};
        default:  rd_err = 1'b1;
      endcase
    end
  end

  // page data buffer, byte lanes honoured
  always_ff @(posedge aclk) begin
    if (wr_take && s_axi_awaddr >= BUF_BASE && s_axi_awaddr <= BUF_END) begin
      for (int i = 0; i < 4; i++) begin
        if (s_axi_wstrb[i]) begin
          page_buf[{s_axi_awaddr[7:2], 2'(i)}] <= s_axi_wdata[i*8 +: 8];
        end
      end
    end
  end

  // command registers and suspend bookkeeping
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      op_r       <= 8'h00;
      addr_r     <= 24'h0;
      len_r      <= 9'h001;
      n_tx       <= 10'h001;
      quad_r     <= 1'b0;
      want_rx    <= 1'b0;
      kind       <= KIND_NONE;
      erase_susp <= 1'b0;
      prog_susp  <= 1'b0;
      refused    <= 1'b0;
      guard      <= 16'h0;
    end else begin
      if (guard != 16'h0) begin
        guard <= guard - 16'h1;
      end
      if (wr_take && s_axi_awaddr == REG_ADDR) begin
        addr_r <= 24'(merge({8'h0, addr_r}, s_axi_wdata, s_axi_wstrb));
      end
      if (wr_take && s_axi_awaddr == REG_LEN) begin
        len_r <= 9'(merge({23'h0, len_r}, s_axi_wdata, s_axi_wstrb));
      end
      if (cmd_sel) begin
        refused <= cmd_bad;
      end
      if (cmd_go) begin
        op_r    <= wr_op;
        n_tx    <= next_n_tx;
        quad_r  <= wr_op == OP_QPP;
        want_rx <= wr_op == OP_RDSR;
        if (is_prog(wr_op)) begin
          kind <= KIND_PROG;
        end else if (wr_op == OP_CE1 || wr_op == OP_CE2) begin
          kind <= KIND_CHIP;
        end else if (is_erase(wr_op)) begin
          kind <= KIND_ERASE;
        end
        if (wr_op == OP_SUSP) begin
          erase_susp <= kind == KIND_ERASE;
          prog_susp  <= kind == KIND_PROG;
        end
        if (wr_op == OP_RESM) begin
          erase_susp <= 1'b0;
          prog_susp  <= 1'b0;
          guard      <= SUSP_CYC;
        end
      end
    end
  end

  // opcode byte, on four lines for quad program
  assign lane_op = lane_load(wr_op, wr_op == OP_QPP);

  // byte source for the frame
  always_comb begin
    case (byte_idx + 9'd1)
      9'd1:    lane_nx = lane_load(addr_r[23:16], quad_r);
      9'd2:    lane_nx = lane_load(addr_r[15:8], quad_r);
      9'd3:    lane_nx = lane_load(addr_r[7:0], quad_r);
      default: lane_nx = lane_load(page_buf[8'(byte_idx - 9'd3)], quad_r);
    endcase
  end

  // serial engine: mode 0, shift on falling, flash samples on rising
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state      <= ST_IDLE;
      flash_o    <= '{cs_n: 1'b1, sclk: 1'b0, io_o: 4'h0, io_oe: 4'h0};
      sh         <= 8'h00;
      units_left <= 3'd0;
      rx_left    <= 4'd0;
      rx_sh      <= 8'h00;
      byte_idx   <= 9'd0;
      div_cnt    <= 4'h0;
      stat_byte  <= 8'h00;
    end else begin
      case (state)
        ST_IDLE: begin
          if (cmd_go) begin
            flash_o.cs_n  <= 1'b0;
            flash_o.io_o  <= lane_op.io;
            flash_o.io_oe <= (wr_op == OP_QPP) ? 4'hf : 4'h1;
            sh            <= lane_op.sh;
            units_left    <= lane_op.left;
            byte_idx      <= 9'd0;
            div_cnt       <= 4'h0;
            state         <= ST_XFER;
          end
        end
        ST_XFER, ST_RECV: begin
          if (div_cnt == SCLK_HALF_CYC - 4'h1) begin
            div_cnt <= 4'h0;
            if (!flash_o.sclk) begin
              flash_o.sclk <= 1'b1;
              if (state == ST_RECV) begin
                rx_sh   <= {rx_sh[6:0], io_s2[1]};
                rx_left <= rx_left - 4'd1;
              end
            end else begin
              flash_o.sclk <= 1'b0;
              if (state == ST_RECV) begin
                if (rx_left == 4'd0) begin
                  stat_byte     <= rx_sh;
                  flash_o.cs_n  <= 1'b1;
                  state         <= ST_GAP;
                end
              end else if (units_left != 3'd0) begin
                // four lanes per unit in quad frames
                flash_o.io_o <= quad_r ? sh[7:4] : {3'b000, sh[7]};
                sh           <= quad_r ? {sh[3:0], 4'h0} : {sh[6:0], 1'b0};
                units_left   <= units_left - 3'd1;
              end else if ({1'b0, byte_idx} + 10'd1 < n_tx) begin
                byte_idx     <= byte_idx + 9'd1;
                flash_o.io_o <= lane_nx.io;
                sh           <= lane_nx.sh;
                units_left   <= lane_nx.left;
              end else if (want_rx) begin
                state         <= ST_RECV;
                rx_left       <= STAT_BITS;
                flash_o.io_oe <= 4'h0;
              end else begin
                // release after the last bit of the last byte
                flash_o.cs_n  <= 1'b1;
                flash_o.io_oe <= 4'h0;
                state         <= ST_GAP;
              end
            end
          end else begin
            div_cnt <= div_cnt + 4'h1;
          end
        end
        ST_GAP: begin
          if (div_cnt == CS_GAP_CYC - 4'h1) begin
            div_cnt <= 4'h0;
            state   <= ST_IDLE;
          end else begin
            div_cnt <= div_cnt + 4'h1;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // checks on frames and suspend bookkeeping
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  chk_qpp_frame_len: assert property (
    cmd_go && wr_op == OP_QPP |=> n_tx >= 10'd5 && n_tx <= 10'd260 && quad_r)
    else $error("quad program frame length out of range");
  chk_quad_lanes_out: assert property (
    state == ST_XFER && quad_r |-> flash_o.io_oe == 4'hf)
    else $error("quad frame not driving four lines");
  chk_sector_frame: assert property (
    cmd_go && wr_op == OP_SE |=> n_tx == 10'd4 && state == ST_XFER)
    else $error("sector erase frame not four bytes");
  chk_block_frame: assert property (
    cmd_go && (wr_op == OP_BE32 || wr_op == OP_BE64) |=> n_tx == 10'd4)
    else $error("block erase frame not four bytes");
  chk_chip_frame: assert property (
    cmd_go && (wr_op == OP_CE1 || wr_op == OP_CE2) |=> n_tx == 10'd1)
    else $error("chip erase frame carries an address");
  chk_cs_byte_edge: assert property (
    $rose(flash_o.cs_n) |-> $past(units_left) == 3'd0 && $past(flash_o.sclk) &&
                            $past(rx_left) == 4'd0)
    else $error("chip select released off a byte boundary");
  chk_cs_held_low: assert property (
    $fell(flash_o.cs_n) |-> !flash_o.cs_n throughout (state == ST_XFER)[*8])
    else $error("chip select rose inside a frame");
  chk_erase_locked: assert property (
    cmd_sel && erase_susp && is_erase(wr_op) |-> !cmd_go ##1 refused)
    else $error("erase issued while erase suspended");
  chk_prog_locked: assert property (
    cmd_sel && prog_susp && (is_prog(wr_op) || wr_op == OP_WRSR) |-> !cmd_go ##1 refused)
    else $error("program issued while program suspended");
  chk_suspend_spacing: assert property (
    cmd_go && wr_op == OP_RESM |=> guard == SUSP_CYC ##1 guard == SUSP_CYC - 16'h1)
    else $error("resume did not start suspend spacing");

endmodule

/* File: rtl/fps_pkg.sv */
/*
  fps_pkg: constants, opcodes, register map and carrier types for the
  serial flash program/erase controller.
  assumes: a 20 MHz system clock and a flash part wired in spi mode 0.
*/
package fps_pkg;

  // timing
  localparam int unsigned CLK_NS          = 50;
  localparam int unsigned SCLK_HALF_NS    = 200;
  localparam int unsigned SCLK_HALF_CYC_I = (SCLK_HALF_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [3:0]  SCLK_HALF_CYC   = 4'(SCLK_HALF_CYC_I);
  localparam int unsigned CS_GAP_NS       = 100;
  localparam int unsigned CS_GAP_CYC_I    = (CS_GAP_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [3:0]  CS_GAP_CYC      = 4'(CS_GAP_CYC_I);

  // flash opcodes
  localparam logic [7:0] OP_WRSR  = 8'h01;
  localparam logic [7:0] OP_PP    = 8'h02;
  localparam logic [7:0] OP_RDSR  = 8'h05;
  localparam logic [7:0] OP_QPP   = 8'h32;
  localparam logic [7:0] OP_SECPP = 8'h42;
  localparam logic [7:0] OP_SE    = 8'h20;
  localparam logic [7:0] OP_BE32  = 8'h52;
  localparam logic [7:0] OP_BE64  = 8'hd8;
  localparam logic [7:0] OP_CE1   = 8'hc7;
  localparam logic [7:0] OP_CE2   = 8'h60;
  localparam logic [7:0] OP_SECER = 8'h44;
  localparam logic [7:0] OP_SUSP  = 8'h75;
  localparam logic [7:0] OP_RESM  = 8'h7a;

  // frame geometry
  localparam logic [9:0] ADDR_BYTES = 10'd3;
  localparam logic [8:0] PAGE_BYTES = 9'd256;
  localparam logic [3:0] STAT_BITS  = 4'd8;

  // register map, byte addresses
  localparam int unsigned AXI_AW   = 12;
  localparam logic [11:0] REG_CMD  = 12'h000;
  localparam logic [11:0] REG_ADDR = 12'h004;
  localparam logic [11:0] REG_LEN  = 12'h008;
  localparam logic [11:0] REG_STAT = 12'h00c;
  localparam logic [11:0] BUF_BASE = 12'h100;
  localparam logic [11:0] BUF_END  = 12'h1fc;
  localparam logic [1:0]  RESP_OKAY   = 2'b00;
  localparam logic [1:0]  RESP_SLVERR = 2'b10;

  // pin carrier
  typedef struct packed {
    logic       cs_n;
    logic       sclk;
    logic [3:0] io_o;
    logic [3:0] io_oe;
  } fps_pins_t;

  // one lane step: levels to drive, rest of the byte, units still to go
  typedef struct packed {
    logic [3:0] io;
    logic [7:0] sh;
    logic [2:0] left;
  } fps_lane_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_XFER = 2'b01,
    ST_RECV = 2'b10,
    ST_GAP  = 2'b11
  } fps_state_t;

  typedef enum logic [1:0] {
    KIND_NONE  = 2'b00,
    KIND_PROG  = 2'b01,
    KIND_ERASE = 2'b10,
    KIND_CHIP  = 2'b11
  } fps_kind_t;

  function automatic logic is_erase(input logic [7:0] op);
    return op == OP_SE || op == OP_BE32 || op == OP_BE64 || op == OP_CE1 ||
           op == OP_CE2 || op == OP_SECER;
  endfunction

  function automatic logic is_prog(input logic [7:0] op);
    return op == OP_PP || op == OP_QPP || op == OP_SECPP;
  endfunction

endpackage

/* File: tb/fps_flash_model.sv */
/*
  fps_flash_model: behavioural serial nor flash facing the controller.
  assumes: spi mode 0 pins from the controller; the bench resolves wires.
*/
module fps_flash_model
  import fps_pkg::*;
#(
  parameter int BUSY_CYC = 1500,
  parameter int SUSP_CYC = 6
) (
  // clock and pins
  input  wire logic         aclk,
  input  wire fps_pins_t    pins,
  input  wire logic         quad_lines_enable,
  // data out line
  output logic              do_oe,
  output logic              do_val,
  // state for the bench
  output logic              busy,
  output logic              suspended_flag,
  output logic              write_enable_latch,
  output logic [7:0]        last_op,
  output logic [23:0]       last_addr,
  output int                n_bits,
  output int                n_frames,
  output int                n_bad,
  output logic              quad_seen,
  output logic [255:0][7:0] mem
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [7:0] sh;
  logic [7:0] st;
  logic       susp_prog;
  logic       chip;
  logic       nested;
  int         cnt;
  int         ncnt;
  int         wait_susp;

  // a start while suspended runs nested, the suspended count is kept
  task automatic start(input logic p, input logic c);
    if (suspended_flag) begin
      nested = 1'b1;
      ncnt = BUSY_CYC;
    end else begin
      susp_prog = p;
      chip = c;
      cnt = BUSY_CYC;
    end
    busy = 1'b1;
  endtask

  // power-up state: idle, unsuspended, erased, nothing protected
  initial begin
    {do_oe, do_val, busy, suspended_flag, write_enable_latch, quad_seen} = '0;
    {sh, last_op, last_addr, n_bits, n_frames, n_bad, cnt, ncnt, wait_susp} = '0;
    {susp_prog, chip, nested} = '0;
    mem = '1;
  end

  always @(negedge pins.cs_n) n_bits = 0;

  // shift in bytes, page data wraps
  always @(posedge pins.sclk) begin
    if (!pins.cs_n) begin
      if (n_bits == 0) quad_seen = pins.io_oe[3];
      sh = quad_seen ? {sh[3:0], pins.io_o} : {sh[6:0], pins.io_o[0]};
      n_bits += quad_seen ? 4 : 1;
      if (n_bits % 8 == 0) begin
        if (n_bits == 8) last_op = sh;
        else if (last_op != OP_RDSR && n_bits <= 32) last_addr = {last_addr[15:0], sh};
        else if (last_op == OP_QPP) mem[8'(last_addr[7:0] + (n_bits - 40) / 8)] = sh;
      end
    end
  end

  // status byte out on falling edges, even while busy
  always @(negedge pins.sclk) begin
    if (!pins.cs_n && last_op == OP_RDSR && n_bits >= 8 && n_bits < 16) begin
      st = {6'h00, write_enable_latch, busy};
      do_oe = 1'b1;
      do_val = st[15 - n_bits];
    end
  end

  // frame end: act only on whole bytes, only suspend while busy
  always @(posedge pins.cs_n) begin
    if (n_bits > 0) begin
      do_oe = 1'b0;
      n_frames++;
      if (n_bits % 8 != 0) n_bad++;
      // suspend only during sector, block or page cycles
      else if (busy) begin
        if (last_op == OP_SUSP && !suspended_flag && !chip) begin
          suspended_flag = 1'b1;
          wait_susp = SUSP_CYC;
        end
      end
      else case (last_op)
        8'h06: write_enable_latch = 1'b1;
        OP_QPP: if (write_enable_latch && quad_lines_enable && !(suspended_flag && susp_prog))
          start(1'b1, 1'b0);
        OP_SE, OP_BE32, OP_BE64: if (write_enable_latch && !(suspended_flag && !susp_prog))
          start(1'b0, 1'b0);
        OP_CE1, OP_CE2: if (write_enable_latch && !suspended_flag) start(1'b0, 1'b1);
        OP_RESM: if (suspended_flag) begin
          suspended_flag = 1'b0;
          busy = 1'b1;
        end
        default: ;
      endcase
    end
  end

  // self-timed cycles, latch cleared on completion
  always @(posedge aclk) begin
    if (wait_susp > 0) begin
      wait_susp--;
      if (wait_susp == 0) busy = 1'b0;
    end else if (nested) begin
      if (ncnt == 0) begin
        {busy, nested, write_enable_latch} = '0;
      end else ncnt--;
    end else if (busy && !suspended_flag) begin
      if (cnt == 0) begin
        busy = 1'b0;
        write_enable_latch = 1'b0;
      end else cnt--;
    end
  end
endmodule

/* File: tb/testbench.sv */
/*
  testbench: drives the flash controller over axi4-lite against the model.
  assumes: package constants and a 20 MHz clock.
*/
module testbench
  import fps_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  // bus, pins and model view
  logic              aclk = 1'b0, aresetn = 1'b0;
  logic [11:0]       s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0]       s_axi_wdata = '0, s_axi_rdata, st;
  logic [3:0]        s_axi_wstrb = '0, flash_io_i;
  logic              s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic              s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic              s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]        s_axi_bresp, s_axi_rresp, rsp;
  fps_pins_t         flash_o;
  logic              do_oe, do_val, busy, susp, wr_latch, quad;
  logic [7:0]        f_op;
  logic [23:0]       f_addr;
  logic [255:0][7:0] mem;
  int                f_bits, f_frames, f_bad, n_errors = 0, total_checks = 0;

  initial forever #25 aclk = ~aclk;

  fps_ctrl #(.SUSP_LAT_NS(20000)) i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .flash_o, .flash_io_i);

  fps_flash_model #(.BUSY_CYC(1500), .SUSP_CYC(6)) i_flash (.aclk, .pins(flash_o),
    .quad_lines_enable(1'b1), .do_oe, .do_val, .busy, .suspended_flag(susp),
    .write_enable_latch(wr_latch), .last_op(f_op), .last_addr(f_addr), .n_bits(f_bits),
    .n_frames(f_frames), .n_bad(f_bad), .quad_seen(quad), .mem);

  // undriven lines read back inverted so stale levels never pass
  assign flash_io_i[3:2] = flash_o.io_o[3:2] ^ ~flash_o.io_oe[3:2];
  assign flash_io_i[0]   = flash_o.io_o[0] ^ ~flash_o.io_oe[0];
  assign flash_io_i[1]   = flash_o.io_oe[1] ? flash_o.io_o[1] : (do_oe ? do_val : ~do_val);

  task automatic chk(input string nm, input logic [31:0] exp_v, input logic [31:0] got);
    total_checks++;
    if (got !== exp_v) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", nm, exp_v, got);
    end
  endtask

  // one write: address and data together, then the response
  task automatic axi_wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hf;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_awvalid || s_axi_wvalid);
    s_axi_bready <= 1'b1;
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  // one read into st and rsp
  task automatic axi_rd(input logic [11:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    st = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  // launch a command, wait out its frame and the chip-select gap
  task automatic cmd(input logic [7:0] op);
    axi_wr(REG_CMD, {24'h000000, op});
    do axi_rd(REG_STAT); while (st[0] !== 1'b0);
    repeat (3) @(posedge aclk);
  endtask

  task automatic wait_flash;
    while (busy !== 1'b0) @(posedge aclk);
  endtask

  task automatic t_regs;
    axi_rd(REG_LEN);
    chk("len reset", 32'h1, st);
    axi_rd(REG_STAT);
    chk("stat reset", 32'h0, st);
    axi_rd(12'h010);
    chk("unmapped read resp", 32'(RESP_SLVERR), 32'(rsp));
    axi_wr(12'h010, 32'h0);
    chk("unmapped write resp", 32'(RESP_SLVERR), 32'(rsp));
    axi_wr(REG_STAT, 32'hffffffff);
    chk("stat write resp", 32'(RESP_OKAY), 32'(rsp));
  endtask

  task automatic t_erase;
    logic [7:0] ops [5] = '{OP_SE, OP_BE32, OP_BE64, OP_CE1, OP_CE2};
    for (int i = 0; i < 5; i++) begin
      cmd(8'h06);
      axi_wr(REG_ADDR, 32'h00abc000 + i);
      cmd(ops[i]);
      chk("erase opcode", 32'(ops[i]), 32'(f_op));
      chk("erase bits", i < 3 ? 32 : 8, f_bits);
      if (i < 3) chk("erase addr", 32'h00abc000 + i, 32'(f_addr));
      chk("flash busy", 32'h1, 32'(busy));
      cmd(OP_RDSR);
      chk("status while busy", 32'h03, 32'(st[15:8]));
      wait_flash;
      cmd(OP_RDSR);
      chk("status after cycle", 32'h00, 32'(st[15:8]));
    end
    chk("frames off byte edge", 32'h0, f_bad);
  endtask

  task automatic t_quad;
    for (int w = 0; w < 3; w++) axi_wr(BUF_BASE + 12'(4 * w), 32'hd0c0b0a0 + 32'h01010101 * w);
    cmd(8'h06);
    axi_wr(REG_ADDR, 32'h000120fc);
    axi_wr(REG_LEN, 32'h9);
    cmd(OP_QPP);
    chk("quad lines", 32'h1, 32'(quad));
    chk("quad opcode", 32'(OP_QPP), 32'(f_op));
    chk("quad addr", 32'h000120fc, 32'(f_addr));
    chk("quad bits", 32 + 9 * 8, f_bits);
    for (int k = 0; k < 9; k++)
      chk("quad data", 8'ha0 + 8'(16 * (k % 4)) + 8'(k / 4), 32'(mem[8'(252 + k)]));
    wait_flash;
    axi_rd(BUF_BASE + 12'h4);
    chk("buffer readback", 32'hd1c1b1a1, st);
    axi_rd(REG_ADDR);
    chk("address readback", 32'h000120fc, st);
  endtask

  task automatic t_susp_erase;
    logic [7:0] ops [7] = '{OP_WRSR, OP_SE, OP_BE32, OP_BE64, OP_CE1, OP_CE2, OP_SECER};
    int n;
    cmd(8'h06);
    cmd(OP_SE);
    cmd(OP_SUSP);
    chk("suspend taken", 32'h1, 32'(susp));
    chk("erase suspended", 32'h1, 32'(st[2]));
    wait_flash;
    n = f_frames;
    foreach (ops[i]) begin
      cmd(ops[i]);
      chk("refused in erase suspend", 32'h1, 32'(st[1]));
    end
    chk("no frame when refused", n, f_frames);
    cmd(OP_RESM);
    chk("resume clears flag", 32'h0, 32'(susp));
    chk("resume busy", 32'h1, 32'(busy));
    chk("spacing running", 32'h1, 32'(st[4]));
    cmd(OP_SUSP);
    chk("early suspend refused", 32'h1, 32'(st[1]));
    do axi_rd(REG_STAT); while (st[4] !== 1'b0);
    cmd(OP_SUSP);
    chk("late suspend taken", 32'h1, 32'(susp));
    wait_flash;
    cmd(OP_RESM);
    wait_flash;
  endtask

  task automatic t_chip_susp;
    cmd(8'h06);
    cmd(OP_CE1);
    cmd(OP_SUSP);
    chk("suspend in chip erase", 32'h1, 32'(st[1]));
    chk("flash not suspended", 32'h0, 32'(susp));
    wait_flash;
  endtask

  task automatic t_susp_prog;
    logic [7:0] ops [3] = '{OP_QPP, OP_PP, OP_WRSR};
    cmd(8'h06);
    axi_wr(REG_LEN, 32'h1);
    cmd(OP_QPP);
    cmd(OP_SUSP);
    chk("program suspended", 32'h1, 32'(st[3]));
    wait_flash;
    foreach (ops[i]) begin
      cmd(ops[i]);
      chk("refused in program suspend", 32'h1, 32'(st[1]));
    end
    axi_wr(REG_ADDR, 32'h00200000);
    cmd(OP_SE);
    chk("erase in program suspend", 32'h0, 32'(st[1]));
    chk("other sector erasing", 32'h1, 32'(busy));
    wait_flash;
    cmd(OP_RESM);
    chk("program resumed", 32'h0, 32'(st[3]));
    chk("program flag cleared", 32'h0, 32'(susp));
    wait_flash;
    chk("latch after program", 32'h0, 32'(wr_latch));
  endtask

  task automatic finish_test;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // main sequence
  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs;
    t_erase;
    t_quad;
    t_susp_erase;
    t_chip_susp;
    t_susp_prog;
    finish_test;
  end

  // watchdog against a hung handshake
  initial begin
    repeat (80000) @(posedge aclk);
    n_errors++;
    $display("ERROR watchdog expected finish seen hang");
    finish_test;
  end
endmodule
